// ---- design/deser_link_config_regs_defines.vh ----
/*
 Constants for the deserializer link configuration register bank:
 register addresses, field positions, reset values and timing figures.
 Assumes a single 100 MHz reference clock; included by its bare name.
*/
// Overview of operation
// - While the config lock bit is set, writes to any address partner_bus_address through 0x1F are ignored.
// - The own address leaves reset as 1001000 or 1001001, chosen by the cable type select level.
// - Pixel clock range code 00 is 12.5-25 MHz, 01 is 25-50 MHz, 10 is forbidden, 11 auto.
// - Serial rate code 00 is 0.5-1 Gbps, 01 is 1-2 Gbps, 10 and 11 detect automatically.
// - After lock the modulation rate is calibrated once, or every 2, 16 or 256 ms by code.
// - A zero sawtooth divider field means autocalibrate, any other value is the divider.
// - A general purpose input change reaches the far end output within 0.35 ms.
`ifndef DESER_LINK_CONFIG_REGS_DEFINES_VH
`define DESER_LINK_CONFIG_REGS_DEFINES_VH

// Register addresses
`define ADDR_PARTNER        8'h00
`define ADDR_OWN_LOCK       8'h01
`define ADDR_SPREAD_RANGE   8'h02
`define ADDR_MOD_CAL        8'h03
`define LOCK_LAST_ADDR      8'h1F

// Reset values
`define PARTNER_ADDR_RST    7'h40
`define OWN_ADDR_RST        7'h48
`define OWN_ADDR_UPPER      6'h24
`define SPREAD_RST          2'h0
`define PCLK_RANGE_RST      2'h3
`define SERIAL_RATE_RST     2'h3
`define RECAL_RST           2'h0
`define SAWTOOTH_RST        5'h00

// Reserved field read values
`define RSVD_ADDR_LSB       1'h0
`define RSVD_SPREAD_MID     2'h1
`define RSVD_MOD_CAL_BIT    1'h0

// Field positions within the data byte
`define FLD_ADDR            7:1
`define FLD_LOCK            0
`define FLD_SPREAD          7:6
`define FLD_PCLK            3:2
`define FLD_RATE            1:0
`define FLD_RECAL           7:6
`define FLD_SAWTOOTH        4:0

// Field codes
`define PCLK_LOW            2'h0
`define PCLK_HIGH           2'h1
`define PCLK_FORBIDDEN      2'h2
`define RATE_LOW            2'h0
`define RATE_HIGH           2'h1
`define RECAL_ONCE          2'h0
`define RECAL_CODE_2        2'h1
`define RECAL_CODE_16       2'h2

// Timing
`define CLK_FREQ_KHZ        100000
`define RECAL_INT_2_MS      9'h002
`define RECAL_INT_16_MS     9'h010
`define RECAL_INT_256_MS    9'h100
`define GPI_DELAY_US        350
`define CYCLES_PER_MS       (`CLK_FREQ_KHZ)
`define GPI_HOLDOFF_CYCLES  ((`CLK_FREQ_KHZ * `GPI_DELAY_US) / 1000)

`endif

// ---- design/gpi_forwarder.v ----
/*
 General purpose input forwarder: sends each level change of the input
 toward the far end output as a level plus a one-cycle strobe.
 Assumes the input is synchronous to the clock and spaced by its driver.
*/
module gpi_forwarder #(
	parameter HOLDOFF_CYCLES = 35000,
	parameter CNT_W          = 16
) (
	// Clock and reset
	input  wire             clk,
	input  wire             arst_n,
	// Local input
	input  wire             level_in,
	// Toward the far end
	output reg              fwd_level,
	output reg              fwd_strobe
);

	localparam integer     HOLD_INT  = HOLDOFF_CYCLES - 1;
	localparam [CNT_W-1:0] HOLD_LAST = HOLD_INT[CNT_W-1:0];

	reg [CNT_W-1:0] hold;

	// Holdoff keeps link traffic bounded; with spaced inputs it never delays
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fwd_level  <= 1'b0;
			fwd_strobe <= 1'b0;
			hold       <= {CNT_W{1'b0}};
		end else begin
			fwd_strobe <= 1'b0;
			if (level_in != fwd_level && hold == {CNT_W{1'b0}}) begin
				fwd_level  <= level_in;
				fwd_strobe <= 1'b1;
				hold       <= HOLD_LAST;
			end else if (hold != {CNT_W{1'b0}}) begin
				hold <= hold - 1'b1;
			end
		end
	end

endmodule

// ---- design/deser_link_config_regs.v ----
/*
 Link configuration register bank of the deserializer: partner and own
 bus addresses, config lock, spread and range selection, modulation
 recalibration scheduling, and general purpose input forwarding.
 Assumes the control channel delivers one-cycle read and write strobes
 synchronous to REF_CLK, and that lock and detected ranges come from
 the link receiver on the same clock.
*/
`include "deser_link_config_regs_defines.vh"

module deser_link_config_regs #(
	parameter MS_CYCLES   = `CYCLES_PER_MS,
	parameter GPI_HOLDOFF = `GPI_HOLDOFF_CYCLES,
	parameter DIV_W       = 17
) (
	// Clock and reset
	input  wire       REF_CLK,
	input  wire       ARST_N,
	// Control channel register port
	input  wire       REG_WR,
	input  wire       REG_RD,
	input  wire [7:0] REG_ADDR,
	input  wire [7:0] REG_WDATA,
	output reg  [7:0] REG_RDATA,
	output reg        REG_ACK,
	output reg        REG_WIGNORED,
	// Strap
	input  wire       CABLE_TYPE_SELECT_INPUT,
	// Link receiver status
	input  wire       LINK_LOCKED,
	input  wire       DETECTED_PCLK_HIGH,
	input  wire       DETECTED_RATE_HIGH,
	// Configuration outputs
	output reg  [6:0] PARTNER_ADDRESS_FIELD,
	output reg  [6:0] OWN_ADDRESS_FIELD,
	output reg        CONFIG_LOCK_BIT,
	output reg  [1:0] SPREAD_AMOUNT,
	output reg        PCLK_RANGE_HIGH,
	output reg        PCLK_RANGE_AUTO,
	output reg        SERIAL_RATE_HIGH,
	output reg        SERIAL_RATE_AUTO,
	output reg        MOD_CAL_START,
	output reg        SAWTOOTH_AUTO,
	output reg  [4:0] SAWTOOTH_DIVIDER_FIELD,
	// General purpose forwarding
	input  wire       GENERAL_PURPOSE_INPUT,
	output wire       GENERAL_PURPOSE_OUTPUT,
	output wire       GPO_UPDATE
);

	localparam ST_UNLOCKED = 1'b0;
	localparam ST_TRACK    = 1'b1;

	localparam integer     MS_INT  = MS_CYCLES - 1;
	localparam [DIV_W-1:0] MS_LAST = MS_INT[DIV_W-1:0];

	reg  [1:0] pixel_clock_range_field;
	reg  [1:0] serial_rate_range_field;
	reg  [1:0] modulation_recal_interval;
	reg        strap_pending;
	reg  [7:0] read_word;

	reg             state;
	reg             lock_d;
	reg [DIV_W-1:0] ms_div;
	reg             ms_tick;
	reg [8:0]       ms_count;

	wire       wr_blocked;
	wire       wr_ok;
	wire       lock_rise;
	wire [8:0] recal_target;

	// Interval code to milliseconds, zero for calibrate-once
	function [8:0] interval_ms;
		input [1:0] code;
		begin
			case (code)
				`RECAL_ONCE:    interval_ms = 9'h000;
				`RECAL_CODE_2:  interval_ms = `RECAL_INT_2_MS;
				`RECAL_CODE_16: interval_ms = `RECAL_INT_16_MS;
				default:        interval_ms = `RECAL_INT_256_MS;
			endcase
		end
	endfunction

	// The lock also guards its own register, so it holds until reset
	assign wr_blocked = REG_WR && CONFIG_LOCK_BIT && (REG_ADDR <= `LOCK_LAST_ADDR);
	assign wr_ok      = REG_WR && !wr_blocked;

	// Register writes and strap capture
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PARTNER_ADDRESS_FIELD     <= `PARTNER_ADDR_RST;
			OWN_ADDRESS_FIELD         <= `OWN_ADDR_RST;
			CONFIG_LOCK_BIT           <= 1'b0;
			SPREAD_AMOUNT             <= `SPREAD_RST;
			pixel_clock_range_field   <= `PCLK_RANGE_RST;
			serial_rate_range_field   <= `SERIAL_RATE_RST;
			modulation_recal_interval <= `RECAL_RST;
			SAWTOOTH_DIVIDER_FIELD    <= `SAWTOOTH_RST;
			strap_pending             <= 1'b1;
		end else begin
			if (wr_ok) begin
				case (REG_ADDR)
					`ADDR_PARTNER: begin
						PARTNER_ADDRESS_FIELD <= REG_WDATA[`FLD_ADDR];
					end
					`ADDR_OWN_LOCK: begin
						OWN_ADDRESS_FIELD <= REG_WDATA[`FLD_ADDR];
						CONFIG_LOCK_BIT   <= REG_WDATA[`FLD_LOCK];
					end
					`ADDR_SPREAD_RANGE: begin
						SPREAD_AMOUNT           <= REG_WDATA[`FLD_SPREAD];
						pixel_clock_range_field <= REG_WDATA[`FLD_PCLK];
						serial_rate_range_field <= REG_WDATA[`FLD_RATE];
					end
					`ADDR_MOD_CAL: begin
						modulation_recal_interval <= REG_WDATA[`FLD_RECAL];
						SAWTOOTH_DIVIDER_FIELD    <= REG_WDATA[`FLD_SAWTOOTH];
					end
					default: begin
					end
				endcase
			end
			// Strap is sampled after release; it beats a write in that cycle
			if (strap_pending) begin
				OWN_ADDRESS_FIELD <= {`OWN_ADDR_UPPER, CABLE_TYPE_SELECT_INPUT};
				strap_pending     <= 1'b0;
			end
		end
	end

	// Read mux; unmapped addresses read as zero
	always @* begin
		read_word = 8'h00;
		case (REG_ADDR)
			`ADDR_PARTNER:      read_word = {PARTNER_ADDRESS_FIELD, `RSVD_ADDR_LSB};
			`ADDR_OWN_LOCK:     read_word = {OWN_ADDRESS_FIELD, CONFIG_LOCK_BIT};
			`ADDR_SPREAD_RANGE: read_word = {SPREAD_AMOUNT, `RSVD_SPREAD_MID,
				pixel_clock_range_field, serial_rate_range_field};
			`ADDR_MOD_CAL:      read_word = {modulation_recal_interval, `RSVD_MOD_CAL_BIT,
				SAWTOOTH_DIVIDER_FIELD};
			default:            read_word = 8'h00;
		endcase
	end

	// Answer one cycle after the strobe; read data is the pre-write value
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			REG_RDATA    <= 8'h00;
			REG_ACK      <= 1'b0;
			REG_WIGNORED <= 1'b0;
		end else begin
			REG_ACK      <= REG_WR | REG_RD;
			REG_WIGNORED <= wr_blocked;
			if (REG_RD) begin
				REG_RDATA <= read_word;
			end
		end
	end

	// Effective range and divider selection, one cycle behind the fields
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PCLK_RANGE_HIGH  <= 1'b0;
			PCLK_RANGE_AUTO  <= 1'b1;
			SERIAL_RATE_HIGH <= 1'b0;
			SERIAL_RATE_AUTO <= 1'b1;
			SAWTOOTH_AUTO    <= 1'b1;
		end else begin
			// Forbidden pixel code falls back to detection rather than guess
			case (pixel_clock_range_field)
				`PCLK_LOW: begin
					PCLK_RANGE_AUTO <= 1'b0;
					PCLK_RANGE_HIGH <= 1'b0;
				end
				`PCLK_HIGH: begin
					PCLK_RANGE_AUTO <= 1'b0;
					PCLK_RANGE_HIGH <= 1'b1;
				end
				default: begin
					PCLK_RANGE_AUTO <= 1'b1;
					PCLK_RANGE_HIGH <= DETECTED_PCLK_HIGH;
				end
			endcase
			case (serial_rate_range_field)
				`RATE_LOW: begin
					SERIAL_RATE_AUTO <= 1'b0;
					SERIAL_RATE_HIGH <= 1'b0;
				end
				`RATE_HIGH: begin
					SERIAL_RATE_AUTO <= 1'b0;
					SERIAL_RATE_HIGH <= 1'b1;
				end
				default: begin
					SERIAL_RATE_AUTO <= 1'b1;
					SERIAL_RATE_HIGH <= DETECTED_RATE_HIGH;
				end
			endcase
			SAWTOOTH_AUTO <= (SAWTOOTH_DIVIDER_FIELD == `SAWTOOTH_RST);
		end
	end

	assign lock_rise    = LINK_LOCKED && !lock_d;
	assign recal_target = interval_ms(modulation_recal_interval);

	// Millisecond enable, restarted at each lock so intervals are exact
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ms_div  <= {DIV_W{1'b0}};
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= 1'b0;
			if (lock_rise || ms_div == MS_LAST) begin
				ms_div  <= {DIV_W{1'b0}};
				ms_tick <= !lock_rise;
			end else begin
				ms_div <= ms_div + 1'b1;
			end
		end
	end

	// Modulation calibration scheduler
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state         <= ST_UNLOCKED;
			lock_d        <= 1'b0;
			ms_count      <= 9'h000;
			MOD_CAL_START <= 1'b0;
		end else begin
			lock_d        <= LINK_LOCKED;
			MOD_CAL_START <= 1'b0;
			case (state)
				ST_UNLOCKED: begin
					if (lock_rise) begin
						MOD_CAL_START <= 1'b1;
						ms_count      <= 9'h000;
						state         <= ST_TRACK;
					end
				end
				ST_TRACK: begin
					if (!LINK_LOCKED) begin
						state <= ST_UNLOCKED;
					end else if (recal_target == 9'h000) begin
						ms_count <= 9'h000;
					end else if (ms_tick) begin
						// Shortening the interval below the count reached fires on the next millisecond tick
						if (ms_count >= recal_target - 9'h001) begin
							ms_count      <= 9'h000;
							MOD_CAL_START <= 1'b1;
						end else begin
							ms_count <= ms_count + 9'h001;
						end
					end
				end
				default: begin
					state <= ST_UNLOCKED;
				end
			endcase
		end
	end

	gpi_forwarder #(
		.HOLDOFF_CYCLES (GPI_HOLDOFF),
		.CNT_W          (16)
	) u_gpi_forwarder (
		.clk        (REF_CLK),
		.arst_n     (ARST_N),
		.level_in   (GENERAL_PURPOSE_INPUT),
		.fwd_level  (GENERAL_PURPOSE_OUTPUT),
		.fwd_strobe (GPO_UPDATE)
	);

endmodule

// ---- tb/link_cfg_chk.sv ----
/*
 Port checker for the link configuration bank.
 Bound to deser_link_config_regs; sees its ports only.
*/
module link_cfg_chk #(
	parameter int GPI_HOLDOFF = 8
) (
	// Clock and reset
	input wire       REF_CLK,
	input wire       ARST_N,
	// Register port
	input wire       REG_WR,
	input wire       REG_RD,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire [7:0] REG_RDATA,
	input wire       REG_ACK,
	input wire       REG_WIGNORED,
	// Strap and link status
	input wire       CABLE_TYPE_SELECT_INPUT,
	input wire       LINK_LOCKED,
	// Configuration outputs
	input wire       CONFIG_LOCK_BIT,
	input wire [6:0] PARTNER_ADDRESS_FIELD,
	input wire [6:0] OWN_ADDRESS_FIELD,
	input wire       PCLK_RANGE_HIGH,
	input wire       PCLK_RANGE_AUTO,
	input wire       SERIAL_RATE_AUTO,
	input wire       MOD_CAL_START,
	input wire       SAWTOOTH_AUTO,
	input wire [4:0] SAWTOOTH_DIVIDER_FIELD,
	// General purpose forwarding
	input wire       GENERAL_PURPOSE_INPUT,
	input wire       GENERAL_PURPOSE_OUTPUT,
	input wire       GPO_UPDATE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	reg        first;
	reg [31:0] lag;
	// Lag counts cycles the far end output trails the input
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			first <= 1'h1;
			lag   <= 32'h0;
		end else begin
			first <= 1'h0;
			lag   <= (GENERAL_PURPOSE_INPUT != GENERAL_PURPOSE_OUTPUT) ? lag + 32'h1 : 32'h0;
		end
	end
	sequence locked_wr;
		REG_WR && CONFIG_LOCK_BIT && REG_ADDR <= 8'h1F;
	endsequence
	sequence range_wr;
		REG_WR && !CONFIG_LOCK_BIT && REG_ADDR == 8'h02;
	endsequence
	sequence mod_wr;
		REG_WR && !CONFIG_LOCK_BIT && REG_ADDR == 8'h03;
	endsequence
	a_req_acked: assert property ((REG_WR || REG_RD) |=> REG_ACK)
		else $error("request not acknowledged");
	a_lock_refused: assert property (locked_wr |=> REG_WIGNORED && $stable(PARTNER_ADDRESS_FIELD))
		else $error("locked write not refused");
	a_lock_sticky: assert property (CONFIG_LOCK_BIT |=> CONFIG_LOCK_BIT)
		else $error("lock bit cleared");
	a_own_strap: assert property (first |=> OWN_ADDRESS_FIELD == {6'h24, $past(CABLE_TYPE_SELECT_INPUT)})
		else $error("own address not from strap");
	a_range_codes: assert property (range_wr |=> ##1
		PCLK_RANGE_AUTO == $past(REG_WDATA[3], 2)
		&& SERIAL_RATE_AUTO == $past(REG_WDATA[1], 2)
		&& (PCLK_RANGE_AUTO || PCLK_RANGE_HIGH == $past(REG_WDATA[2], 2)))
		else $error("range code not applied");
	a_saw_auto: assert property (mod_wr |=>
		SAWTOOTH_DIVIDER_FIELD == $past(REG_WDATA[4:0])
		##1 SAWTOOTH_AUTO == ($past(REG_WDATA[4:0], 2) == 5'h00))
		else $error("divider setting wrong");
	a_cal_on_lock: assert property ($rose(LINK_LOCKED) |=> MOD_CAL_START)
		else $error("no calibration after lock");
	a_gpo_latency: assert property (lag <= GPI_HOLDOFF + 2)
		else $error("input change forwarded late");
	a_gpo_strobe: assert property (GPO_UPDATE == $changed(GENERAL_PURPOSE_OUTPUT))
		else $error("update strobe mismatch");
	a_rsvd_bits: assert property (REG_RD && REG_ADDR == 8'h02 |=> REG_RDATA[5:4] == 2'h1)
		else $error("reserved bits wrong");
endmodule

bind deser_link_config_regs link_cfg_chk #(.GPI_HOLDOFF(GPI_HOLDOFF)) link_cfg_chk_inst (.*);

// ---- tb/link_partner.sv ----
/*
 Far end model: link lock level and the spaced general purpose input.
 Driven by bench request levels on the same clock.
*/
module link_partner #(
	parameter int SPACING = 10
) (
	// Clock
	input  wire  clk,
	// Bench requests
	input  wire  lock_req,
	input  wire  toggle_req,
	// Toward the block
	output logic locked,
	output logic gpi
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap = 0;
	initial gpi = 1'h0;
	assign locked = lock_req;
	// Held request toggles at the minimum spacing
	always @(posedge clk) begin
		gap <= gap + 1;
		if (toggle_req && gap >= SPACING) begin
			gpi <= ~gpi;
			gap <= 0;
		end
	end
endmodule

// ---- tb/test_deser_link_config_regs.sv ----
/*
 Bench for the link configuration bank: register access tasks, lock,
 range codes, calibration and input forwarding. Needs partner and checker.
*/
module test_deser_link_config_regs;
	timeunit 1ns;
	timeprecision 1ns;
	reg        clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, strap = 1'h1;
	reg        lock_req = 1'h0, tog = 1'h0, det = 1'h0;
	wire [1:0] ss;
	reg  [7:0] addr = 8'h00, wdata = 8'h00;
	wire [7:0] rdata;
	wire       ign, locked, gpi, general_purpose_output, lk, pch, pca, srh, sra, cal, swa;
	wire [4:0] div;
	int        miscompares = 0, checked = 0, cycles = 0, pulses;
	int        span [4] = '{2, 2, 16, 256};
	logic [7:0] rst_v [4] = '{8'h80, 8'h92, 8'h1F, 8'h00};
	logic [7:0] wr_v [4] = '{8'hAB, 8'h90, 8'hFF, 8'hFF};
	logic [7:0] rb_v [4] = '{8'hAA, 8'h90, 8'hDF, 8'hDF};
	deser_link_config_regs #(.MS_CYCLES(10), .GPI_HOLDOFF(8)) deser_link_config_regs_inst (
		.REF_CLK(clk), .ARST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(), .REG_WIGNORED(ign),
		.CABLE_TYPE_SELECT_INPUT(strap), .LINK_LOCKED(locked), .DETECTED_PCLK_HIGH(det),
		.DETECTED_RATE_HIGH(det), .PARTNER_ADDRESS_FIELD(), .OWN_ADDRESS_FIELD(),
		.CONFIG_LOCK_BIT(lk), .SPREAD_AMOUNT(ss), .PCLK_RANGE_HIGH(pch), .PCLK_RANGE_AUTO(pca),
		.SERIAL_RATE_HIGH(srh), .SERIAL_RATE_AUTO(sra), .MOD_CAL_START(cal),
		.SAWTOOTH_AUTO(swa), .SAWTOOTH_DIVIDER_FIELD(div), .GENERAL_PURPOSE_INPUT(gpi),
		.GENERAL_PURPOSE_OUTPUT(general_purpose_output), .GPO_UPDATE());
	link_partner #(.SPACING(10)) link_partner_inst (.clk(clk), .lock_req(lock_req),
		.toggle_req(tog), .locked(locked), .gpi(gpi));
	initial forever #5 clk = ~clk;
	task automatic complete_run;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Longest run is the calibration sweep, near 8300 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run;
		end
	end
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One-cycle strobe; answer is settled when the task returns
	task automatic access(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge clk) #1;
		wr = w;
		rd = !w;
		addr = a;
		wdata = d;
		@(posedge clk) #1;
		wr = 1'h0;
		rd = 1'h0;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			access(0, i, 8'h00);
			check("reset value", rdata, rst_v[i]);
		end
		access(0, 8'h20, 8'h00);
		check("unmapped read", rdata, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			access(1, i, wr_v[i]);
			access(0, i, 8'h00);
			check("readback", rdata, rb_v[i]);
		end
		// Detector level flips halfway so auto codes must follow it
		for (int i = 0; i < 8; i++) begin
			det = i[2];
			access(1, 8'h02, {i[1:0], 2'h1, i[1:0], i[1:0]});
			@(posedge clk) #1;
			check("spread", ss, i[1:0]);
			check("pclk auto", pca, i[1]);
			check("pclk high", pch, i[1] ? i[2] : i[0]);
			check("rate auto", sra, i[1]);
			check("rate high", srh, i[1] ? i[2] : i[0]);
		end
		for (int i = 0; i < 2; i++) begin
			access(1, 8'h03, i * 5);
			@(posedge clk) #1;
			check("saw auto", swa, i == 0);
			check("divider", div, i * 5);
		end
		$display("field codes done");
		for (int c = 0; c < 4; c++) begin
			access(1, 8'h03, {c[1:0], 6'h00});
			lock_req = 1'h1;
			pulses = 0;
			repeat (span[c] * 30 + 5) begin
				@(posedge clk) #1;
				pulses += cal;
			end
			check("cal pulses", pulses, c ? 4 : 1);
			lock_req = 1'h0;
			@(posedge clk) #1;
		end
		$display("calibration done");
		// Five spaced toggles leave the input high, unlike the reset level
		tog = 1'h1;
		repeat (50) @(posedge clk);
		#1 tog = 1'h0;
		repeat (12) @(posedge clk);
		#1 check("gpi level", gpi, 1'h1);
		check("gpo level", general_purpose_output, 1'h1);
		$display("forwarding done");
		access(1, 8'h01, 8'h91);
		access(1, 8'h00, 8'h22);
		check("ignored", ign, 1'h1);
		access(1, 8'h01, 8'h00);
		access(1, 8'h20, 8'h00);
		check("unmapped ignored", ign, 1'h0);
		access(0, 8'h00, 8'h00);
		check("locked reg0", rdata, 8'hAA);
		access(0, 8'h01, 8'h00);
		check("locked reg1", rdata, 8'h91);
		$display("lock done");
		rst_n = 1'h0;
		strap = 1'h0;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (2) @(posedge clk);
		access(0, 8'h01, 8'h00);
		check("strap low", rdata, 8'h90);
		$display("second reset done");
		complete_run;
	end
endmodule
